//--- hdl/pbs_defs.vh
// Timing constants and the summary of operation for the push-button power sequencer.
// Summary of operation
// - Power up after qualified press above upper threshold
// - Supply dip during press restarts qualify timer
// - Qualified press: enable on, reset pulse
// - Keep-alive low at release drops enable
// - Window expiry with button held samples keep-alive
// - No monitoring until power-up completes
// - Pull-down on keep-alive during startup
// - Keep-alive low in normal operation drops enable
// - Undervoltage below lower threshold drives alert low
// - Long undervoltage drops enable
// - Qualified press gives alert pulse
// - Alert low from qualify end while held
// - Alert low at least minimum width
// - Alert high throughout power-up
// - Button-state output tells alert cause
// - Two-button long push acts per option
// - Reset option: long push pulses reset
// - Power-off option: long push drops enable
// - Reset option: no keep-alive drops enable
// - Watch second button falling edges after power-up
// - Standby watches only power button falling edge
// - Active-low enable is inverse of enable
// - No timing cap means zero extra time
// - Button-state low min width then follows release
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

// =============================================
// Time base
// =============================================
`define PBS_CLK_HZ          25000000
`define PBS_QUALIFY_US      30000
`define PBS_RESET_US        200000
`define PBS_BLANK_US        10000000
`define PBS_ALERT_MIN_US    30000
`define PBS_LONG_EXTRA_US   1000000
`define PBS_US_CYCLES(t)    (((t) * 25) )
`define PBS_CNT_W           32

`endif

//--- hdl/pbs_sync.v
// Two-flop synchroniser for a bank of asynchronous inputs.
`timescale 1ns/1ps
module pbs_sync #(
	parameter WIDTH = 4
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// Data
	input  wire [WIDTH-1:0] async_in,
	input  wire [WIDTH-1:0] rst_val,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	// Reset is synchronous, so the reset level may come from a constant wire.
	always @(posedge clk) begin
		if (!rst_n) begin
			meta     <= rst_val;
			sync_out <= rst_val;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

//--- hdl/pbs_sequencer.v
// Push-button power sequencer: power-up qualification, startup confirm, alerts and long push.
`timescale 1ns/1ps
`include "pbs_defs.vh"
module pbs_sequencer #(
	parameter [31:0] QUALIFY_CYC  = `PBS_US_CYCLES(`PBS_QUALIFY_US),
	parameter [31:0] RESET_CYC    = `PBS_US_CYCLES(`PBS_RESET_US),
	parameter [31:0] BLANK_CYC    = `PBS_US_CYCLES(`PBS_BLANK_US),
	parameter [31:0] ALERT_CYC    = `PBS_US_CYCLES(`PBS_ALERT_MIN_US),
	parameter [31:0] LONG_CYC     = `PBS_US_CYCLES(`PBS_LONG_EXTRA_US),
	parameter        LONG_RESET   = 1'b1
) (
	// Clock and reset
	input  wire clk,
	input  wire rst_n,
	// Buttons, active low
	input  wire power_button_in,
	input  wire second_button_in,
	// Host keep-alive, supply comparators and long-push timing cap
	input  wire keep_alive_in,
	input  wire above_upper_in,
	input  wire above_lower_in,
	input  wire long_press_timing_cap,
	// Outputs
	output reg  power_en,
	output reg  power_en_n,
	output reg  host_reset_n,
	output reg  alert_n,
	output reg  button_state_out,
	output reg  keep_alive_pulldown
);
	localparam [2:0] ST_STANDBY = 3'h0;
	localparam [2:0] ST_QUALIFY = 3'h1;
	localparam [2:0] ST_STARTUP = 3'h2;
	localparam [2:0] ST_NORMAL  = 3'h3;
	localparam [2:0] ST_LPRESET = 3'h4;

	wire [4:0] s;
	// Buttons idle high, keep-alive idles low, comparators idle as healthy.
	pbs_sync #(.WIDTH(5)) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({power_button_in, second_button_in, keep_alive_in, above_upper_in, above_lower_in}),
		.rst_val  (5'h1B),
		.sync_out (s)
	);
	wire pb_held = ~s[4];
	wire sr_held = ~s[3];
	wire ka      = s[2];
	wire up_ok   = s[1];
	wire lo_ok   = s[0];

	reg  [2:0]  state;
	reg  [31:0] tmr;      // qualify / startup window / long-push confirm window
	reg  [31:0] rst_tmr;
	reg  [31:0] uv_tmr;
	reg  [31:0] lp_tmr;
	reg  [31:0] pb_tmr;
	reg  [31:0] al_tmr;
	reg         pb_prev;
	reg         sr_prev;
	reg         sr_armed;
	reg         pb_qual;
	reg         startup_pb;
	reg         en;

	// Extra long-push time is dropped when no timing cap is fitted.
	wire [31:0] long_need = QUALIFY_CYC + ALERT_CYC + (long_press_timing_cap ? LONG_CYC : 32'h0);
	wire        pb_fall   = pb_held & ~pb_prev;
	wire        sr_fall   = sr_held & ~sr_prev;
	wire        uv_long   = (uv_tmr >= long_need);
	wire        lp_hit    = pb_held & sr_held & sr_armed & (lp_tmr >= long_need);
	wire        alert_req = (~lo_ok) | pb_qual;

	always @(posedge clk) begin
		if (!rst_n) begin
			state      <= ST_STANDBY;
			tmr        <= 32'h0;
			rst_tmr    <= 32'h0;
			uv_tmr     <= 32'h0;
			lp_tmr     <= 32'h0;
			pb_tmr     <= 32'h0;
			al_tmr     <= 32'h0;
			pb_prev    <= 1'b0;
			sr_prev    <= 1'b0;
			sr_armed   <= 1'b0;
			pb_qual    <= 1'b0;
			startup_pb <= 1'b0;
			en         <= 1'b0;
			power_en   <= 1'b0;
			power_en_n <= 1'b1;
			host_reset_n        <= 1'b1;
			alert_n             <= 1'b1;
			button_state_out    <= 1'b1;
			keep_alive_pulldown <= 1'b0;
		end else begin
			pb_prev <= pb_held;
			sr_prev <= sr_held;
			if (rst_tmr != 32'h0)
				rst_tmr <= rst_tmr - 32'h1;
			// Low for exactly the loaded count: one cycle per value from the load down to one.
			host_reset_n <= (rst_tmr == 32'h0);
			case (state)
			ST_STANDBY: begin
				en <= 1'b0;
				alert_n <= 1'b1;
				button_state_out <= 1'b1;
				if (pb_fall) begin
					state <= ST_QUALIFY;
					tmr   <= 32'h0;
				end
			end
			ST_QUALIFY: begin
				if (!pb_held)
					state <= ST_STANDBY;
				else if (!up_ok)
					tmr <= 32'h0;
				else if (tmr >= QUALIFY_CYC - 32'h1) begin
					state      <= ST_STARTUP;
					en         <= 1'b1;
					rst_tmr    <= RESET_CYC;
					tmr        <= 32'h0;
					startup_pb <= 1'b1;
				end else
					tmr <= tmr + 32'h1;
			end
			ST_STARTUP, ST_LPRESET: begin
				// Alert stays idle until the host confirms
				alert_n <= 1'b1;
				tmr <= tmr + 32'h1;
				if (!pb_held)
					startup_pb <= 1'b0;
				if (startup_pb && !pb_held && state == ST_STARTUP && tmr < BLANK_CYC) begin
					if (ka) begin
						state <= ST_NORMAL;
					end else begin
						state <= ST_STANDBY;
						en    <= 1'b0;
					end
				end else if (tmr >= BLANK_CYC - 32'h1) begin
					// Keep-alive is sampled exactly at window expiry
					if (ka)
						state <= ST_NORMAL;
					else begin
						state <= ST_STANDBY;
						en    <= 1'b0;
					end
				end
				uv_tmr   <= 32'h0;
				lp_tmr   <= 32'h0;
				pb_qual  <= 1'b0;
				pb_tmr   <= 32'h0;
				sr_armed <= 1'b0;
			end
			ST_NORMAL: begin
				// Second button arms only on a falling edge
				if (sr_fall)
					sr_armed <= 1'b1;
				else if (!sr_held)
					sr_armed <= 1'b0;
				if (pb_held && sr_held)
					lp_tmr <= lp_tmr + 32'h1;
				else
					lp_tmr <= 32'h0;
				uv_tmr <= lo_ok ? 32'h0 : uv_tmr + 32'h1;
				// Presses during undervoltage are ignored by the button qualifier.
				if (pb_held && lo_ok && ka) begin
					if (pb_tmr < QUALIFY_CYC)
						pb_tmr <= pb_tmr + 32'h1;
					else
						pb_qual <= 1'b1;
				end else begin
					pb_tmr <= 32'h0;
					if (al_tmr == 32'h0)
						pb_qual <= 1'b0;
				end
				if (alert_req && alert_n) begin
					alert_n <= 1'b0;
					al_tmr  <= ALERT_CYC;
				end else if (al_tmr != 32'h0)
					al_tmr <= al_tmr - 32'h1;
				else if (!alert_req)
					alert_n <= 1'b1;
				// Low only for a button cause, so the host can tell it from undervoltage.
				button_state_out <= ~(pb_qual | (pb_tmr >= QUALIFY_CYC));
				if (!ka || uv_long) begin
					state <= ST_STANDBY;
					en    <= 1'b0;
				end else if (lp_hit) begin
					lp_tmr <= 32'h0;
					if (LONG_RESET) begin
						state   <= ST_LPRESET;
						rst_tmr <= RESET_CYC;
						tmr     <= 32'h0;
					end else begin
						state <= ST_STANDBY;
						en    <= 1'b0;
					end
				end
			end
			default: begin
				state <= ST_STANDBY;
				en    <= 1'b0;
			end
			endcase
			power_en   <= en;
			power_en_n <= ~en;
			keep_alive_pulldown <= (state == ST_STARTUP) | (state == ST_LPRESET) | (state == ST_QUALIFY);
		end
	end
endmodule

//--- verification/pbs_seq_asserts.sv
// Port-level checks for the push-button power sequencer.
`timescale 1ns/1ps
module pbs_seq_asserts (
	input logic clk, rst_n,
	input logic power_button_in, second_button_in, keep_alive_in,
	input logic above_upper_in, above_lower_in, long_press_timing_cap,
	input logic power_en, power_en_n, host_reset_n,
	input logic alert_n, button_state_out, keep_alive_pulldown
);
	// =============================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Past the reset pulse and with the pull-down off, the host owns keep-alive.
	wire normal = power_en && !keep_alive_pulldown;
	sequence s_rst_pulse;
		!host_reset_n [*8];
	endsequence
	sequence s_alert_min;
		!alert_n [*8];
	endsequence
	AST_EN_INV: assert property (power_en_n == !power_en)
		else $error("enable pair not inverse");
	AST_UP_BTN: assert property ($rose(power_en) |-> !power_button_in)
		else $error("power-up without held button");
	AST_UP_RST: assert property ($rose(power_en) |-> ##[0:1] (!host_reset_n && keep_alive_pulldown))
		else $error("power-up without reset or pull-down");
	AST_RST_MIN: assert property ($fell(host_reset_n) |-> s_rst_pulse)
		else $error("reset pulse too short");
	AST_QUIET: assert property (keep_alive_pulldown |-> alert_n)
		else $error("alert during power-up");
	AST_KA_DROP: assert property (normal && $past(host_reset_n, 4) && host_reset_n && $fell(keep_alive_in)
		|-> ##[1:5] !power_en)
		else $error("enable kept after keep-alive low");
	AST_UV: assert property (normal && $fell(above_lower_in) |-> ##[1:5] !alert_n)
		else $error("no alert on undervoltage");
	AST_ALERT_MIN: assert property ($fell(alert_n) |-> s_alert_min)
		else $error("alert too short");
endmodule
bind pbs_sequencer pbs_seq_asserts chk (.*);

//--- verification/pbs_host.sv
// Host processor model that answers on keep-alive.
`timescale 1ns/1ps
module pbs_host #(
	parameter DLY = 2
) (
	input  wire clk,
	input  wire ok,
	input  wire power_en,
	input  wire host_reset_n,
	input  wire keep_alive_pulldown,
	output wire keep_alive_in
);
	reg  [3:0] cnt = 4'h0;
	reg        tgl = 1'b0;
	wire       run = power_en && host_reset_n;
	// =============================================
	// Pin drive
	// An undriven pin wanders unless the device pull-down holds it low.
	always @(posedge clk) begin
		tgl <= ~tgl;
		cnt <= !run ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
	end
	assign keep_alive_in = (run && !ok) ? 1'b0 : ((run && cnt >= DLY) ? 1'b1 :
		(keep_alive_pulldown ? 1'b0 : tgl));
endmodule

//--- verification/pbs_sequencer_test.sv
// Self-checking bench for the push-button power sequencer.
`timescale 1ns/1ps
module pbs_sequencer_test;
	logic clk = 1'b0, rst_n = 1'b0, ok = 1'b1, long_press_timing_cap = 1'b0;
	logic power_button_in = 1'b1, second_button_in = 1'b1, above_upper_in = 1'b1, above_lower_in = 1'b1;
	wire keep_alive_in, power_en, power_en_n, host_reset_n, alert_n, button_state_out, keep_alive_pulldown;
	wire [2:0] st = {power_en, alert_n, host_reset_n};
	logic [2:0] exp_q[$];
	event chk;
	int mismatches = 0;
	int comparisons = 0;
	always #20 clk = ~clk;
	pbs_sequencer #(.QUALIFY_CYC(32'h8), .RESET_CYC(32'h8), .BLANK_CYC(32'h40), .ALERT_CYC(32'h8),
		.LONG_CYC(32'h8)) dut (.clk, .rst_n, .power_button_in, .second_button_in, .keep_alive_in,
		.above_upper_in, .above_lower_in, .long_press_timing_cap, .power_en, .power_en_n,
		.host_reset_n, .alert_n, .button_state_out, .keep_alive_pulldown);
	pbs_host host (.clk, .ok, .power_en, .host_reset_n, .keep_alive_pulldown, .keep_alive_in);
	// =============================================
	// Tasks
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic note(input logic [2:0] v);
		exp_q.push_back(v);
		-> chk;
	endtask
	task automatic wait_for(input logic [2:0] v, input int lim);
		int i;
		@(negedge clk);
		for (i = 0; i < lim && st !== v; i++) @(negedge clk);
		if (st !== v) begin
			mismatches++;
			$display("[ERR] %0t wait ran out", $time);
			stop_test();
		end
		note(v);
	endtask
	always @(chk) begin
		comparisons++;
		if (st !== exp_q.pop_front()) begin
			mismatches++;
			$display("[ERR] %0t outputs %b", $time, st);
		end
	end
	// =============================================
	// Scenarios
	initial begin
		void'($urandom(32'h60454f0d));
		tick(3);
		rst_n = 1'b1;
		tick(2);
		power_button_in = 1'b0;
		tick(6);
		above_upper_in = 1'b0;
		tick(2);
		above_upper_in = 1'b1;
		tick(6);
		note(3'b011);
		wait_for(3'b110, 40);
		tick(14);
		power_button_in = 1'b1;
		tick(5);
		note(3'b111);
		$display("power-up test done");
		above_lower_in = 1'b0;
		tick(3);
		above_lower_in = 1'b1;
		wait_for(3'b101, 10);
		comparisons++;
		if (button_state_out !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t button cause shown for undervoltage", $time);
		end
		wait_for(3'b111, 30);
		power_button_in = 1'b0;
		tick(20);
		note(3'b101);
		comparisons++;
		if (button_state_out !== 1'b0) begin
			mismatches++;
			$display("[ERR] %0t button cause not shown", $time);
		end
		power_button_in = 1'b1;
		wait_for(3'b111, 30);
		$display("alert test done");
		long_press_timing_cap = 1'($urandom);
		second_button_in = 1'b0;
		tick(2);
		power_button_in = 1'b0;
		// Alert is forced idle while the long-push reset runs.
		wait_for(3'b110, 60);
		power_button_in = 1'b1;
		second_button_in = 1'b1;
		wait_for(3'b111, 80);
		// Let the confirm window after the long push run out before the host lets go.
		tick(64);
		note(3'b111);
		$display("long push test done");
		ok = 1'b0;
		wait_for(3'b011, 10);
		power_button_in = 1'b0;
		wait_for(3'b110, 40);
		tick(12);
		power_button_in = 1'b1;
		wait_for(3'b011, 5);
		$display("shutdown test done");
		stop_test();
	end
endmodule
